/* File: pllh_pkg.sv */
// constants for the pll holdover and lock control block
package pllh_pkg;
   // register word indices (byte address = index * 4)
   localparam logic [9:0] IDX_STATUS_PIN = 10'h017;
   localparam logic [9:0] IDX_LOCK_DET = 10'h018;
   localparam logic [9:0] IDX_LD_PIN = 10'h01A;
   localparam logic [9:0] IDX_REFERENCE_MONITOR_PIN_PIN = 10'h01B;
   localparam logic [9:0] IDX_REF_SEL = 10'h01C;
   localparam logic [9:0] IDX_HOLD_CFG = 10'h01D;
   localparam logic [9:0] IDX_STATE = 10'h040;
   localparam logic [9:0] IDX_CHARGE_TC = 10'h041;
   // field positions
   localparam int STATUS_SEL_LSB = 2;
   localparam int LOCK_CNT_LSB = 5;
   localparam int LOCK_WIN_BIT = 4;
   localparam int DLD_OFF_BIT = 3;
   localparam int REF_SEL_LSB = 1;
   localparam int HOLD_EN0_BIT = 0;
   localparam int HOLD_EXT_BIT = 1;
   localparam int HOLD_EN2_BIT = 2;
   localparam int CMP_EN_BIT = 3;
   // lock pin selector codes
   localparam logic [5:0] LD_SEL_DLD = 6'h00;
   localparam logic [5:0] LD_SEL_ALD = 6'h01;
   localparam logic [5:0] LD_SEL_CSRC = 6'h04;
   // comparator codes on the monitor and status pin selectors
   localparam logic [4:0] REFERENCE_MONITOR_PIN_CMP_HI = 5'h0A;
   localparam logic [4:0] REFERENCE_MONITOR_PIN_CMP_LO = 5'h1A;
   localparam logic [5:0] STATUS_CMP_HI = 6'h0A;
   localparam logic [5:0] STATUS_CMP_LO = 6'h1A;
   // consecutive in-window cycles per lock counter code
   localparam logic [7:0] LOCK_CYC_0 = 8'h05;
   localparam logic [7:0] LOCK_CYC_1 = 8'h10;
   localparam logic [7:0] LOCK_CYC_2 = 8'h40;
   localparam logic [7:0] LOCK_CYC_3 = 8'hFF;
   // reset values
   localparam logic [5:0] RST_STATUS_SEL = 6'h00;
   localparam logic [6:0] RST_LOCK_DET = 7'h00;
   localparam logic [5:0] RST_LD_SEL = 6'h00;
   localparam logic [4:0] RST_REFERENCE_MONITOR_PIN_SEL = 5'h00;
   localparam logic [3:0] RST_REF_SEL = 4'h0;
   localparam logic [3:0] RST_HOLD_CFG = 4'h0;
   localparam logic [15:0] RST_CHARGE_TC = 16'h0100;
   typedef enum logic [1:0] {HO_IDLE, HO_HOLD, HO_REARM} pllh_ho_t;
endpackage

/* File: pllh_holdover_ctrl.sv */
// holdover, lock detect and lock pin control with an ahb-lite register slave
`timescale 1ns/1ps
module pllh_holdover_ctrl
#(
   parameter int LOCK_W = 8,
   parameter int CHARGE_W = 16
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic syncPinN,
   input wire logic pfdRefEdge,
   input wire logic phaseInLockHi,
   input wire logic phaseInLockLo,
   input wire logic phaseBeyondUnlock,
   input wire logic analogLockFlag,
   output logic chargePumpHiZ,
   output logic bCounterReset,
   output logic digitalLockFlag,
   output logic lockPinOut,
   output logic lockPinOe,
   output logic lockPinSource,
   output logic referenceMonitorPin,
   output logic statusPin,
   output logic autoSwitchEn,
   output logic preferSecondRef,
   output logic [1:0] refBufEn
);
   import pllh_pkg::*;

   initial
   begin
      if (LOCK_W < 8 || CHARGE_W < 1 || CHARGE_W > 16)
      begin
         $error("pllh_holdover_ctrl: unsupported counter widths");
      end
   end

   typedef struct packed {
      logic [5:0] statusSel;
      logic [1:0] lockCnt;
      logic lockWin;
      logic dldOff;
      logic [5:0] ldSel;
      logic [4:0] refmonSel;
      logic [3:0] refSel;
      logic [3:0] holdCfg;
      logic [CHARGE_W-1:0] chargeTc;
      logic wrPend;
      logic [9:0] wrIdx;
      logic [31:0] rdata;
      logic readyOut;
      logic [2:0] syncPipe;
      logic syncLevel;
      logic digital_lock_flag;
      logic [LOCK_W-1:0] inWinCnt;
      logic [CHARGE_W-1:0] chargeCnt;
      pllh_ho_t hoState;
      logic cpHiZ;
      logic bReset;
      logic ldOut;
      logic ldOe;
      logic ldSrc;
      logic reference_monitor_pin;
      logic status;
   } pllh_state_t;

   localparam pllh_state_t ST_RESET = '{
      statusSel: RST_STATUS_SEL,
      lockCnt: RST_LOCK_DET[6:5],
      lockWin: RST_LOCK_DET[4],
      dldOff: RST_LOCK_DET[3],
      ldSel: RST_LD_SEL,
      refmonSel: RST_REFERENCE_MONITOR_PIN_SEL,
      refSel: RST_REF_SEL,
      holdCfg: RST_HOLD_CFG,
      chargeTc: RST_CHARGE_TC[CHARGE_W-1:0],
      wrPend: 1'b0,
      wrIdx: 10'h000,
      rdata: 32'h0000_0000,
      readyOut: 1'b1,
      syncPipe: 3'h7,
      syncLevel: 1'b1,
      digital_lock_flag: 1'b0,
      inWinCnt: '0,
      chargeCnt: '0,
      hoState: HO_IDLE,
      cpHiZ: 1'b0,
      bReset: 1'b0,
      ldOut: 1'b0,
      ldOe: 1'b0,
      ldSrc: 1'b0,
      reference_monitor_pin: 1'b0,
      status: 1'b0
   };

   pllh_state_t st;
   pllh_state_t next_st;

   logic hoEn;
   logic manualMode;
   logic cmpEn;
   logic cmpOut;
   logic ldRaw;
   logic ldLevel;
   logic inLock;
   logic syncFall;
   logic syncAgree;
   logic addrOk;
   logic [LOCK_W-1:0] lockNeed;
   logic [9:0] rdIdx;

   //////////////////////////////////////////////////////////////////////////
   // decoded configuration and lock pin level
   always_comb
   begin
      hoEn = st.holdCfg[HOLD_EN0_BIT] & st.holdCfg[HOLD_EN2_BIT];
      manualMode = st.holdCfg[HOLD_EXT_BIT];
      cmpEn = st.holdCfg[CMP_EN_BIT];
      // comparator trips once the modelled capacitor reaches its threshold
      cmpOut = (st.chargeCnt >= st.chargeTc);
      case (st.ldSel)
         LD_SEL_DLD: ldRaw = st.digital_lock_flag;
         LD_SEL_ALD: ldRaw = analogLockFlag;
         LD_SEL_CSRC: ldRaw = cmpOut;
         default: ldRaw = 1'b0;
      endcase
      ldLevel = cmpEn ? ldRaw : 1'b1;
      inLock = st.lockWin ? phaseInLockLo : phaseInLockHi;
      case (st.lockCnt)
         2'b00: lockNeed = LOCK_W'(LOCK_CYC_0);
         2'b01: lockNeed = LOCK_W'(LOCK_CYC_1);
         2'b10: lockNeed = LOCK_W'(LOCK_CYC_2);
         default: lockNeed = LOCK_W'(LOCK_CYC_3);
      endcase
      syncAgree = (st.syncPipe[1] == st.syncPipe[2]);
      syncFall = syncAgree & st.syncLevel & ~st.syncPipe[2];
      addrOk = (haddr[31:12] == 20'h00000) && (haddr[1:0] == 2'b00);
      rdIdx = haddr[11:2];
   end

   //////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      next_st = st;
      next_st.bReset = 1'b0;

      // bus: zero wait states, write lands in the data phase
      next_st.readyOut = 1'b1;
      if (st.wrPend)
      begin
         case (st.wrIdx)
            IDX_STATUS_PIN: next_st.statusSel = hwdata[STATUS_SEL_LSB +: 6];
            IDX_LOCK_DET:
            begin
               next_st.lockCnt = hwdata[LOCK_CNT_LSB +: 2];
               next_st.lockWin = hwdata[LOCK_WIN_BIT];
               next_st.dldOff = hwdata[DLD_OFF_BIT];
            end
            IDX_LD_PIN: next_st.ldSel = hwdata[5:0];
            IDX_REFERENCE_MONITOR_PIN_PIN: next_st.refmonSel = hwdata[4:0];
            IDX_REF_SEL: next_st.refSel = hwdata[REF_SEL_LSB +: 4];
            IDX_HOLD_CFG: next_st.holdCfg = hwdata[3:0];
            IDX_CHARGE_TC: next_st.chargeTc = hwdata[CHARGE_W-1:0];
            default: next_st.chargeTc = st.chargeTc;
         endcase
      end
      next_st.wrPend = 1'b0;
      if (hsel && htrans[1] && hready)
      begin
         next_st.wrPend = hwrite && addrOk;
         next_st.wrIdx = rdIdx;
         next_st.rdata = 32'h0000_0000;
         if (!hwrite && addrOk)
         begin
            case (rdIdx)
               IDX_STATUS_PIN: next_st.rdata[STATUS_SEL_LSB +: 6] = st.statusSel;
               IDX_LOCK_DET: next_st.rdata[6:3] = {st.lockCnt, st.lockWin, st.dldOff};
               IDX_LD_PIN: next_st.rdata[5:0] = st.ldSel;
               IDX_REFERENCE_MONITOR_PIN_PIN: next_st.rdata[4:0] = st.refmonSel;
               IDX_REF_SEL: next_st.rdata[REF_SEL_LSB +: 4] = st.refSel;
               IDX_HOLD_CFG: next_st.rdata[3:0] = st.holdCfg;
               IDX_STATE: next_st.rdata[6:0] = {st.hoState, ldLevel, st.syncLevel,
                                                 st.cpHiZ, cmpOut, st.digital_lock_flag};
               IDX_CHARGE_TC: next_st.rdata[CHARGE_W-1:0] = st.chargeTc;
               default: next_st.rdata = 32'h0000_0000;
            endcase
         end
      end

      // sync pin: three stages, a change counts once the last two agree
      next_st.syncPipe = {st.syncPipe[1:0], syncPinN};
      if (syncAgree)
      begin
         next_st.syncLevel = st.syncPipe[2];
      end

      // digital lock detect, evaluated once per reference phase detector edge
      if (st.dldOff)
      begin
         next_st.digital_lock_flag = 1'b0;
         next_st.inWinCnt = '0;
      end
      else if (pfdRefEdge)
      begin
         if (phaseBeyondUnlock)
         begin
            next_st.digital_lock_flag = 1'b0;
            next_st.inWinCnt = '0;
         end
         else if (inLock)
         begin
            if (st.inWinCnt != {LOCK_W{1'b1}})
            begin
               next_st.inWinCnt = st.inWinCnt + 1'b1;
            end
            if (st.inWinCnt + 1'b1 >= lockNeed)
            begin
               next_st.digital_lock_flag = 1'b1;
            end
         end
         else
         begin
            // between the two windows: flag holds, run starts over
            next_st.inWinCnt = '0;
         end
      end

      // capacitor model: any unlocked cycle discharges at once
      if (!st.digital_lock_flag)
      begin
         next_st.chargeCnt = '0;
      end
      else if (!cmpOut)
      begin
         next_st.chargeCnt = st.chargeCnt + 1'b1;
      end

      // holdover sequencing
      case (st.hoState)
         HO_IDLE:
         begin
            if (hoEn && manualMode && syncFall)
            begin
               next_st.hoState = HO_HOLD;
               next_st.cpHiZ = 1'b1;
            end
            else if (hoEn && !manualMode && !ldLevel)
            begin
               next_st.hoState = HO_HOLD;
               next_st.cpHiZ = 1'b1;
            end
         end
         HO_HOLD:
         begin
            // pfdRefEdge is the selected reference, so a switchover blip ends here
            if (pfdRefEdge && (!manualMode || st.syncLevel))
            begin
               next_st.hoState = manualMode ? HO_IDLE : HO_REARM;
               next_st.cpHiZ = 1'b0;
               next_st.bReset = 1'b1;
            end
            else
            begin
               next_st.cpHiZ = 1'b1;
            end
         end
         HO_REARM:
         begin
            // avoids retriggering while the loop is still reacquiring
            if (ldLevel)
            begin
               next_st.hoState = HO_IDLE;
            end
         end
         default: next_st.hoState = HO_IDLE;
      endcase
      if (!hoEn)
      begin
         next_st.hoState = HO_IDLE;
         next_st.cpHiZ = 1'b0;
         next_st.bReset = 1'b0;
      end

      // lock indicator pin drive
      next_st.ldSrc = 1'b0;
      next_st.ldOut = 1'b0;
      next_st.ldOe = 1'b0;
      case (st.ldSel)
         LD_SEL_DLD:
         begin
            next_st.ldOut = next_st.digital_lock_flag;
            next_st.ldOe = 1'b1;
         end
         LD_SEL_ALD:
         begin
            next_st.ldOut = analogLockFlag;
            next_st.ldOe = 1'b1;
         end
         LD_SEL_CSRC:
         begin
            next_st.ldSrc = next_st.digital_lock_flag;
            next_st.ldOe = ~next_st.digital_lock_flag;
         end
         default: next_st.ldOe = 1'b0;
      endcase

      // comparator routed to monitor and status pins
      case (st.refmonSel)
         REFERENCE_MONITOR_PIN_CMP_HI: next_st.reference_monitor_pin = cmpOut;
         REFERENCE_MONITOR_PIN_CMP_LO: next_st.reference_monitor_pin = ~cmpOut;
         default: next_st.reference_monitor_pin = 1'b0;
      endcase
      case (st.statusSel)
         STATUS_CMP_HI: next_st.status = cmpOut;
         STATUS_CMP_LO: next_st.status = ~cmpOut;
         default: next_st.status = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st <= ST_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // outputs straight from the state register, except hresp which is tied low
   assign hrdata = st.rdata;
   assign hreadyout = st.readyOut;
   assign hresp = 1'b0;
   assign chargePumpHiZ = st.cpHiZ;
   assign bCounterReset = st.bReset;
   assign digitalLockFlag = st.digital_lock_flag;
   assign lockPinOut = st.ldOut;
   assign lockPinOe = st.ldOe;
   assign lockPinSource = st.ldSrc;
   assign referenceMonitorPin = st.reference_monitor_pin;
   assign statusPin = st.status;
   assign autoSwitchEn = st.refSel[3];
   assign preferSecondRef = st.refSel[2];
   assign refBufEn = st.refSel[1:0];

   //////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   chk_manual_entry: assert property (
      (st.hoState == HO_IDLE && hoEn && manualMode && syncFall) |=> st.cpHiZ ##0 !st.bReset)
      else $error("manual holdover not entered on sync fall");
   chk_release_edge: assert property (
      ($fell(st.cpHiZ) && $past(hoEn)) |-> $past(pfdRefEdge))
      else $error("charge pump released without reference edge");
   chk_hold_noref: assert property (
      (st.cpHiZ && !pfdRefEdge && hoEn) |=> st.cpHiZ)
      else $error("charge pump left hi-z without reference edge");
   chk_breset_pair: assert property (
      st.bReset |-> ($fell(st.cpHiZ) ##1 !st.bReset))
      else $error("feedback reset not paired with release");
   chk_auto_entry: assert property (
      (st.hoState == HO_IDLE && hoEn && !manualMode && !ldLevel) |=> st.cpHiZ)
      else $error("automatic holdover missed on lost lock");
   chk_cmp_off: assert property (
      (hoEn && !manualMode && !cmpEn && !st.cpHiZ) |=> !st.cpHiZ)
      else $error("holdover entered with comparator disabled");
   chk_disabled_idle: assert property (
      !hoEn |=> (!st.cpHiZ && !st.bReset && st.hoState == HO_IDLE))
      else $error("holdover active while disabled");
   chk_rearm_wait: assert property (
      (st.hoState == HO_REARM && !ldLevel) |=> !st.cpHiZ)
      else $error("holdover re-entered before lock pin charged");
   chk_lock_five: assert property (
      ($rose(st.digital_lock_flag) && st.lockCnt == 2'b00 && $stable(st.lockCnt))
         |-> $past(st.inWinCnt) == LOCK_W'(4))
      else $error("lock flagged after wrong cycle count");
   chk_dld_drop: assert property (
      (pfdRefEdge && phaseBeyondUnlock) |=> !st.digital_lock_flag)
      else $error("lock flag kept after unlock cycle");
   chk_csrc_clamp: assert property (
      ($past(st.ldSel) == LD_SEL_CSRC) |-> (st.ldOe == !st.digital_lock_flag && st.ldSrc == st.digital_lock_flag))
      else $error("current source pin drive wrong");
   chk_charge_clear: assert property (
      !st.digital_lock_flag |=> st.chargeCnt == '0)
      else $error("charge counter not cleared on unlock");
endmodule // pllh_holdover_ctrl

/* File: pllh_loop_model.sv */
// phase detector side model: reference edge pulses and phase window status
`timescale 1ns/1ps
module pllh_loop_model
(
   input wire logic ref_clk,
   input wire logic runEdges,
   input wire logic inWin,
   input wire logic winLo,
   input wire logic beyond,
   output logic pfdRefEdge,
   output logic phaseInLockHi,
   output logic phaseInLockLo,
   output logic phaseBeyondUnlock
);
   logic [1:0] phase = 2'h0;
   initial
   begin
      pfdRefEdge = 1'b0;
      phaseInLockHi = 1'b0;
      phaseInLockLo = 1'b0;
      phaseBeyondUnlock = 1'b0;
   end
   always @(posedge ref_clk)
   begin
      phase <= phase + 2'h1;
      pfdRefEdge <= runEdges && phase == 2'h3;
      if (runEdges && phase == 2'h3)
      begin
         phaseInLockHi <= inWin & ~winLo;
         phaseInLockLo <= inWin & winLo;
         phaseBeyondUnlock <= beyond;
      end
      else
      begin
         // qualifiers only mean something beside an edge pulse
         phaseInLockHi <= ~phaseInLockHi;
         phaseInLockLo <= ~phaseInLockLo;
         phaseBeyondUnlock <= ~phaseBeyondUnlock;
      end
   end
endmodule // pllh_loop_model

/* File: pllh_holdover_ctrl_bench.sv */
// self-checking bench for the holdover and lock control block
`timescale 1ns/1ps
module pllh_holdover_ctrl_bench;
   import pllh_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, v;
   logic hreadyout, hresp, syncPinN = 1'b1, analogLockFlag = 1'b0;
   logic runEdges = 1'b0, inWin = 1'b0, winLo = 1'b0, beyond = 1'b0;
   logic pfdRefEdge, phaseInLockHi, phaseInLockLo, phaseBeyondUnlock;
   logic chargePumpHiZ, bCounterReset, digitalLockFlag, lockPinOut, lockPinOe;
   logic lockPinSource, referenceMonitorPin, statusPin, autoSwitchEn, preferSecondRef;
   logic [1:0] refBufEn;
   int failures = 0;
   int testsRun = 0;
   int cyc [4];
   always #5 ref_clk = ~ref_clk;
   pllh_loop_model loop (.ref_clk(ref_clk), .runEdges(runEdges), .inWin(inWin),
      .winLo(winLo), .beyond(beyond), .pfdRefEdge(pfdRefEdge),
      .phaseInLockHi(phaseInLockHi), .phaseInLockLo(phaseInLockLo),
      .phaseBeyondUnlock(phaseBeyondUnlock));
   pllh_holdover_ctrl uut (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .syncPinN(syncPinN), .pfdRefEdge(pfdRefEdge), .phaseInLockHi(phaseInLockHi),
      .phaseInLockLo(phaseInLockLo), .phaseBeyondUnlock(phaseBeyondUnlock),
      .analogLockFlag(analogLockFlag), .chargePumpHiZ(chargePumpHiZ),
      .bCounterReset(bCounterReset), .digitalLockFlag(digitalLockFlag),
      .lockPinOut(lockPinOut), .lockPinOe(lockPinOe), .lockPinSource(lockPinSource),
      .referenceMonitorPin(referenceMonitorPin), .statusPin(statusPin),
      .autoSwitchEn(autoSwitchEn), .preferSecondRef(preferSecondRef),
      .refBufEn(refBufEn));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp)
      begin
         failures++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic endOfTest;
      $display("checks %0d mismatches %0d", testsRun, failures);
      if (failures == 0 && testsRun > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic waitc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // address phase held until hready, then data phase held until hready
   task automatic busCycle(input logic [9:0] idx, input logic wr, input logic [31:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1;
      haddr <= {20'h0, idx, 2'b00};
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) @(posedge ref_clk);
      v = hrdata;
   endtask
   task automatic wr(input logic [9:0] idx, input logic [31:0] d);
      busCycle(idx, 1'b1, d);
      // write lands at the closing edge, pins driven from it settle one edge later
      waitc(2);
   endtask
   task automatic rd(input logic [9:0] idx);
      busCycle(idx, 1'b0, 32'h0);
   endtask
   task automatic edges(input int n);
      int k;
      k = 0;
      @(posedge ref_clk);
      runEdges <= 1'b1;
      while (k < n)
      begin
         @(posedge ref_clk);
         if (pfdRefEdge === 1'b1)
            k++;
      end
      runEdges <= 1'b0;
   endtask
   task automatic unlock;
      inWin <= 1'b0;
      beyond <= 1'b1;
      edges(1);
      beyond <= 1'b0;
      inWin <= 1'b1;
      waitc(6);
   endtask
   // the pump must let go on the edge after the reference pulse, with one reset pulse
   task automatic releaseHold;
      edges(1);
      @(posedge ref_clk);
      check("hiz", 32'(chargePumpHiZ), 32'h0);
      check("bres", 32'(bCounterReset), 32'h1);
      @(posedge ref_clk);
      check("bres", 32'(bCounterReset), 32'h0);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #200000;
      failures++;
      endOfTest();
   end
   initial
   begin
      cyc = '{int'(LOCK_CYC_0), int'(LOCK_CYC_1), int'(LOCK_CYC_2), int'(LOCK_CYC_3)};
      waitc(5);
      rst_n <= 1'b1;
      rd(IDX_HOLD_CFG);
      check("holdcfg", v, 32'(RST_HOLD_CFG));
      rd(IDX_CHARGE_TC);
      check("chargetc", v, 32'(RST_CHARGE_TC));
      wr(10'h3FF, 32'hFFFFFFFF);
      rd(10'h3FF);
      check("unmapped", v, 32'h0);
      check("hresp", 32'(hresp), 32'h0);
      check("hready", 32'(hreadyout), 32'h1);
      wr(IDX_REF_SEL, 32'h1E);
      check("refsel", 32'({autoSwitchEn, preferSecondRef, refBufEn}), 32'hF);
      wr(IDX_REF_SEL, 32'h16);
      check("refsel", 32'({autoSwitchEn, preferSecondRef, refBufEn}), 32'hB);
      inWin <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         wr(IDX_LOCK_DET, 32'(i) << LOCK_CNT_LSB);
         edges(cyc[i] - 1);
         waitc(3);
         check("dldearly", 32'(digitalLockFlag), 32'h0);
         edges(1);
         waitc(3);
         check("dldcount", 32'(digitalLockFlag), 32'h1);
         unlock();
         check("dldloss", 32'(digitalLockFlag), 32'h0);
      end
      wr(IDX_LOCK_DET, 32'h0);
      winLo <= 1'b1;
      edges(8);
      waitc(3);
      check("winhigh", 32'(digitalLockFlag), 32'h0);
      wr(IDX_LOCK_DET, 32'h10);
      edges(5);
      waitc(3);
      check("winlow", 32'(digitalLockFlag), 32'h1);
      winLo <= 1'b0;
      wr(IDX_LOCK_DET, 32'h08);
      edges(8);
      waitc(3);
      check("dldoff", 32'(digitalLockFlag), 32'h0);
      wr(IDX_LOCK_DET, 32'h0);
      edges(5);
      wr(IDX_HOLD_CFG, 32'h05);
      unlock();
      check("cmpoff", 32'(chargePumpHiZ), 32'h0);
      edges(5);
      wr(IDX_HOLD_CFG, 32'h0D);
      waitc(4);
      check("locked", 32'(chargePumpHiZ), 32'h0);
      check("ldpin", 32'({lockPinOe, lockPinOut}), 32'h3);
      unlock();
      check("auto", 32'(chargePumpHiZ), 32'h1);
      waitc(30);
      check("noref", 32'(chargePumpHiZ), 32'h1);
      releaseHold();
      waitc(12);
      check("rearm", 32'(chargePumpHiZ), 32'h0);
      edges(5);
      unlock();
      check("reenter", 32'(chargePumpHiZ), 32'h1);
      releaseHold();
      edges(5);
      wr(IDX_HOLD_CFG, 32'h09);
      unlock();
      check("halfen", 32'(chargePumpHiZ), 32'h0);
      wr(IDX_CHARGE_TC, 32'h20);
      wr(IDX_LD_PIN, 32'(LD_SEL_CSRC));
      wr(IDX_REFERENCE_MONITOR_PIN_PIN, 32'(REFERENCE_MONITOR_PIN_CMP_HI));
      wr(IDX_STATUS_PIN, 32'(STATUS_CMP_LO) << STATUS_SEL_LSB);
      check("clamp", 32'({lockPinSource, lockPinOe, lockPinOut}), 32'h2);
      check("cmplo", 32'({referenceMonitorPin, statusPin}), 32'h1);
      edges(5);
      waitc(3);
      check("source", 32'(lockPinSource), 32'h1);
      check("charging", 32'(referenceMonitorPin), 32'h0);
      waitc(40);
      check("charged", 32'({referenceMonitorPin, statusPin}), 32'h2);
      unlock();
      check("discharge", 32'({lockPinSource, referenceMonitorPin}), 32'h0);
      wr(IDX_HOLD_CFG, 32'h0D);
      waitc(6);
      check("csrcauto", 32'(chargePumpHiZ), 32'h1);
      releaseHold();
      wr(IDX_HOLD_CFG, 32'h02);
      syncPinN <= 1'b0;
      waitc(8);
      check("syncoff", 32'(chargePumpHiZ), 32'h0);
      wr(IDX_HOLD_CFG, 32'h07);
      waitc(8);
      check("levelonly", 32'(chargePumpHiZ), 32'h0);
      syncPinN <= 1'b1;
      waitc(8);
      syncPinN <= 1'b0;
      waitc(6);
      check("manual", 32'(chargePumpHiZ), 32'h1);
      edges(2);
      waitc(2);
      check("synclow", 32'(chargePumpHiZ), 32'h1);
      syncPinN <= 1'b1;
      waitc(30);
      check("manualnoref", 32'(chargePumpHiZ), 32'h1);
      releaseHold();
      wr(IDX_LD_PIN, 32'(LD_SEL_ALD));
      analogLockFlag <= 1'b1;
      waitc(2);
      check("aldpin", 32'({lockPinOe, lockPinOut}), 32'h3);
      rd(IDX_HOLD_CFG);
      check("holdrb", v, 32'h7);
      // analog flag low as lock source trips automatic holdover
      analogLockFlag <= 1'b0;
      wr(IDX_HOLD_CFG, 32'h0D);
      waitc(2);
      check("aldauto", 32'(chargePumpHiZ), 32'h1);
      releaseHold();
      endOfTest();
   end
endmodule // pllh_holdover_ctrl_bench
